// [core/slsi_converter.sv]
// Top of the serial sampling converter: trigger sequencer and readout
`timescale 1ns/100ps
module slsi_converter #(
    parameter int CONVERT_COUNT = slsi_pkg::CONVERT_CYCLES
) (
    // System clock and reset
    input  wire logic                              clock,
    input  wire logic                              reset,
    // Host serial port pins
    input  wire logic                              link_sclk,
    input  wire logic                              select_n,
    input  wire logic                              frame_sync_strobe,
    output logic                                   serial_data,
    output logic                                   serial_data_oe_n,
    // Sampler front end
    input  wire logic [slsi_pkg::RESULT_WIDTH-1:0] sample_value,
    output logic                                   sampler_hold
);
    import slsi_pkg::*;

    // Count loaded at each conversion start
    localparam logic [COUNT_WIDTH-1:0] CONVERT_LOAD =
        COUNT_WIDTH'(CONVERT_COUNT - 1);
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO  = '0;
    localparam logic [COUNT_WIDTH-1:0] COUNT_STEP  = COUNT_WIDTH'(1);

    // Filtered pin levels
    logic [1:0]              pin_raw;
    logic [1:0]              pin_level;
    logic                    select_level_n;
    logic                    fs_level;

    // Edge detection state
    logic                    select_prev_n;
    logic                    next_select_prev_n;
    logic                    fs_prev;
    logic                    next_fs_prev;
    logic                    select_fall;
    logic                    select_rise;
    logic                    fs_fall;

    // Sequencer state
    slsi_state_type          state;
    slsi_state_type          next_state;
    slsi_mode_type           mode;
    slsi_mode_type           next_mode;
    logic [COUNT_WIDTH-1:0]  count;
    logic [COUNT_WIDTH-1:0]  next_count;
    logic [RESULT_WIDTH-1:0] held_sample;
    logic [RESULT_WIDTH-1:0] next_held_sample;
    logic                    start_convert;
    logic                    convert_done;

    // Result store
    logic [RESULT_WIDTH-1:0] pending;
    logic [RESULT_WIDTH-1:0] next_pending;
    logic                    pending_valid;
    logic                    next_pending_valid;
    logic [WORD_WIDTH-1:0]   frame_word;
    logic [WORD_WIDTH-1:0]   next_frame_word;

    // Carrier to the link-side shifter
    slsi_link_if link_bus ();

    // Pins arrive from the host's domain and must be filtered here
    assign pin_raw = {select_n, frame_sync_strobe};

    slsi_pin_filter #(
        .WIDTH       (2),
        .RESET_VALUE ({SELECT_IDLE, SYNC_IDLE})
    ) u_pin_filter (
        .clock (clock),
        .reset (reset),
        .pin   (pin_raw),
        .level (pin_level)
    );

    assign select_level_n = pin_level[1];
    assign fs_level       = pin_level[0];

    // Edge history of the filtered levels
    always_comb begin
        next_select_prev_n = select_level_n;
        next_fs_prev       = fs_level;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            select_prev_n <= SELECT_IDLE;
            fs_prev       <= SYNC_IDLE;
        end else begin
            select_prev_n <= next_select_prev_n;
            fs_prev       <= next_fs_prev;
        end
    end

    // One-cycle events on the system clock
    assign select_fall = select_prev_n && !select_level_n;
    assign select_rise = !select_prev_n && select_level_n;
    assign fs_fall     = fs_prev && !fs_level && !select_level_n;

    // Sequencer: picks the mode at the select fall and times the conversion
    always_comb begin
        next_state       = state;
        next_mode        = mode;
        next_count       = count;
        next_held_sample = held_sample;
        start_convert    = 1'b0;
        convert_done     = 1'b0;
        case (state)
            SLSI_IDLE: begin
                if (select_fall) begin
                    if (fs_level) begin
                        next_mode     = SLSI_MODE_SELECT;
                        start_convert = 1'b1;
                    end else begin
                        next_mode  = SLSI_MODE_FRAME;
                        next_state = SLSI_WAIT_FS;
                    end
                end
            end
            SLSI_WAIT_FS: begin
                if (select_level_n) begin
                    // Frame ended with no frame sync: nothing to convert
                    next_state = SLSI_IDLE;
                end else if (fs_fall) begin
                    start_convert = 1'b1;
                end
            end
            SLSI_CONVERT: begin
                if (select_level_n) begin
                    // Early release throws the conversion away
                    next_state = SLSI_IDLE;
                end else if (count == COUNT_ZERO) begin
                    convert_done = 1'b1;
                    next_state   = SLSI_IDLE;
                end else begin
                    next_count = count - COUNT_STEP;
                end
            end
            default: begin
                next_state = SLSI_IDLE;
            end
        endcase
        if (start_convert) begin
            next_state       = SLSI_CONVERT;
            next_count       = CONVERT_LOAD;
            next_held_sample = sample_value;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state       <= SLSI_IDLE;
            mode        <= SLSI_MODE_SELECT;
            count       <= COUNT_ZERO;
            held_sample <= RESULT_RESET;
        end else begin
            state       <= next_state;
            mode        <= next_mode;
            count       <= next_count;
            held_sample <= next_held_sample;
        end
    end

    // Sampler holds its input while a conversion runs
    assign sampler_hold = (state == SLSI_CONVERT);

    // Result store: a finished result waits until the frame closes, because
    // the word being shifted out must stay stable for the link clock domain
    always_comb begin
        next_pending       = pending;
        next_pending_valid = pending_valid;
        next_frame_word    = frame_word;
        if (convert_done) begin
            next_pending       = held_sample;
            next_pending_valid = 1'b1;                     // Internal only, never a pin
        end else if (pending_valid && select_level_n && !select_rise) begin
            next_frame_word    = {pending, PAD_BITS};
            next_pending_valid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pending       <= RESULT_RESET;
            pending_valid <= 1'b0;
            frame_word    <= WORD_RESET;
        end else begin
            pending       <= next_pending;
            pending_valid <= next_pending_valid;
            frame_word    <= next_frame_word;
        end
    end

    // Word stays still for a whole frame and mode from just after the select fall, so the link reads them as levels
    assign link_bus.frame_word = frame_word;
    assign link_bus.mode       = mode;

    // Link-side shifter; select high holds it in reset between frames
    slsi_link_shift u_link_shift (
        .link_sclk         (link_sclk),
        .select_n          (select_n),
        .frame_sync_strobe (frame_sync_strobe),
        .link              (link_bus.link),
        .serial_data       (serial_data),                  // Send-only data path
        .serial_data_oe_n  (serial_data_oe_n)
    );

endmodule : slsi_converter

// [core/slsi_link_if.sv]
// Interface carrying the frame word and trigger mode to the link logic
`timescale 1ns/100ps
interface slsi_link_if;
    import slsi_pkg::*;

    logic [WORD_WIDTH-1:0] frame_word;
    slsi_mode_type         mode;

    // Core writes the word while select is high and the mode at the select fall; link only reads during a frame
    modport core (output frame_word, output mode);
    modport link (input frame_word, input mode);

endinterface : slsi_link_if

// [core/slsi_link_shift.sv]
// Serial output shifter running on the host's serial clock
`timescale 1ns/100ps
module slsi_link_shift (
    // Link clock and frame select from the host
    input  wire logic  link_sclk,
    input  wire logic  select_n,
    input  wire logic  frame_sync_strobe,
    // Word and mode from the core
    slsi_link_if.link  link,
    // Serial data pin
    output logic       serial_data,
    output logic       serial_data_oe_n
);
    import slsi_pkg::*;

    logic [3:0] bit_index;
    logic [3:0] next_bit_index;
    logic       shifting;
    logic       next_shifting;
    logic       fs_prev;
    logic       next_fs_prev;
    logic       advance;

    // Frame sync is launched by the host on this same clock, so no synchroniser
    always_comb begin
        next_fs_prev   = frame_sync_strobe;
        next_shifting  = shifting;
        next_bit_index = bit_index;
        advance        = (link.mode == SLSI_MODE_SELECT) || shifting;
        if (fs_prev && !frame_sync_strobe) begin
            next_shifting = 1'b1;
        end
        if (advance && (bit_index != BIT_INDEX_LAST)) begin
            next_bit_index = bit_index + BIT_INDEX_STEP;
        end
    end

    // Select high ends the frame, so the clock may stop between frames
    always_ff @(negedge link_sclk or posedge select_n) begin
        if (select_n) begin
            bit_index <= 4'h0;
            shifting  <= 1'b0;
            fs_prev   <= 1'b0;
        end else begin
            bit_index <= next_bit_index;
            shifting  <= next_shifting;
            fs_prev   <= next_fs_prev;
        end
    end

    // Index 0 picks the top bit; after bit 15 the zero pad keeps showing
    assign serial_data      = link.frame_word[BIT_INDEX_LAST - bit_index];
    assign serial_data_oe_n = select_n;

endmodule : slsi_link_shift

// [core/slsi_pin_filter.sv]
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/100ps
module slsi_pin_filter #(
    parameter int               WIDTH       = 2,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // System clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // Raw pins and filtered levels
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    import slsi_pkg::*;

    genvar lane;
    generate
        for (lane = 0; lane < WIDTH; lane++) begin : g_lane
            logic stage1;
            logic stage2;
            logic stage3;
            logic filtered;
            logic next_filtered;

            // A change counts only once stages two and three agree
            always_comb begin
                next_filtered = filtered;
                if (stage2 == stage3) begin
                    next_filtered = stage3;
                end
            end

            // Stage one feeds only stage two
            always_ff @(posedge clock) begin
                if (reset) begin
                    stage1   <= RESET_VALUE[lane];
                    stage2   <= RESET_VALUE[lane];
                    stage3   <= RESET_VALUE[lane];
                    filtered <= RESET_VALUE[lane];
                end else begin
                    stage1   <= pin[lane];
                    stage2   <= stage1;
                    stage3   <= stage2;
                    filtered <= next_filtered;
                end
            end

            assign level[lane] = filtered;
        end
    endgenerate

endmodule : slsi_pin_filter

// [core/slsi_pkg.sv]
// Package of constants and types for the serial sampling converter interface
// Notes on behaviour
// - Frame sync high at select fall picks select-triggered mode for that frame.
// - Select-triggered mode starts a sample and convert on every select fall.
// - While select is low, previous result shifts out, one bit per falling clock.
// - Frame sync low at select fall picks frame-sync-triggered mode.
// - Frame-sync mode starts conversion only after a falling frame sync.
// - Frame-sync mode holds the top bit until frame sync falls, then shifts.
// - Words go out most significant bit first, least significant last.
// - No writable registers; the serial port only sends data.
// - Logic comes out of power-up in a defined state with no setup.
// - No interrupt and no conversion-complete signal; host relies on timing.
// - Select released before conversion ends abandons it; no result kept.
// - Each conversion result has 12 bits of resolution.
// - Result fills the word's top 12 bits; four zero bits follow.
package slsi_pkg;

    // Word layout
    localparam int          RESULT_WIDTH   = 12;
    localparam int          PAD_WIDTH      = 4;
    localparam int          WORD_WIDTH     = RESULT_WIDTH + PAD_WIDTH;
    localparam logic [3:0]  PAD_BITS       = 4'h0;
    localparam logic [3:0]  BIT_INDEX_LAST = 4'hf;
    localparam logic [3:0]  BIT_INDEX_STEP = 4'h1;

    // Reset values
    localparam logic [11:0] RESULT_RESET   = 12'h000;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic        SELECT_IDLE    = 1'b1;
    localparam logic        SYNC_IDLE      = 1'b0;

    // Timing: conversion must fit the least select-low time, so round down
    localparam real         CLOCK_PERIOD_NS = 10.0;
    localparam real         CONVERT_TIME_US = 4.5;
    localparam int          CONVERT_CYCLES_RAW =
        int'($floor(CONVERT_TIME_US * 1000.0 / CLOCK_PERIOD_NS));
    localparam int          CONVERT_CYCLES =
        (CONVERT_CYCLES_RAW < 1) ? 1 : CONVERT_CYCLES_RAW;
    localparam int          COUNT_WIDTH    = 13;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SLSI_IDLE    = 3'b001,
        SLSI_WAIT_FS = 3'b010,
        SLSI_CONVERT = 3'b100
    } slsi_state_type;

    // Trigger mode chosen at the select fall
    typedef enum logic {
        SLSI_MODE_FRAME  = 1'b0,
        SLSI_MODE_SELECT = 1'b1
    } slsi_mode_type;

endpackage : slsi_pkg

// [sim/slsi_converter_assertions.sv]
// Checker of the converter's pin behaviour
`timescale 1ns/100ps
module slsi_converter_assertions
    import slsi_pkg::*;
#(
    parameter int CONVERT_COUNT = CONVERT_CYCLES
) (
    // System side
    input wire logic                    clock,
    input wire logic                    reset,
    // Host pins
    input wire logic                    link_sclk,
    input wire logic                    select_n,
    input wire logic                    frame_sync_strobe,
    input wire logic                    serial_data,
    input wire logic                    serial_data_oe_n,
    // Sampler front end
    input wire logic [RESULT_WIDTH-1:0] sample_value,
    input wire logic                    sampler_hold
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    int hold_cnt;
    int next_hold_cnt;

    // Length of the running conversion in clocks
    always_comb begin
        next_hold_cnt = sampler_hold ? hold_cnt + 1 : 0;
    end
    always_ff @(posedge clock) begin
        hold_cnt <= next_hold_cnt;
    end

    // The pin filter costs a few clocks before a conversion starts
    sequence s_conv_start;
        ##[2:8] sampler_hold;
    endsequence
    sequence s_idle_8;
        !sampler_hold [*8];
    endsequence

    a_oe_follows_select: assert property (serial_data_oe_n == select_n)
        else $error("output enable does not follow select");
    a_select_start: assert property (
        $fell(select_n) && frame_sync_strobe |-> s_conv_start)
        else $error("no conversion after select fall");
    a_frame_waits: assert property (
        $fell(select_n) && !frame_sync_strobe |-> s_idle_8)
        else $error("conversion started before frame sync fall");
    a_sync_start: assert property (
        $fell(frame_sync_strobe) && !select_n && !sampler_hold |-> s_conv_start)
        else $error("no conversion after frame sync fall");
    a_conv_length: assert property (
        $fell(sampler_hold) && !select_n
        |-> hold_cnt inside {[CONVERT_COUNT-1:CONVERT_COUNT+1]})
        else $error("conversion length wrong");
    a_one_per_frame: assert property ($fell(sampler_hold) && !select_n |=> s_idle_8)
        else $error("second conversion in one frame");
    a_abort_drop: assert property (
        $rose(select_n) && sampler_hold |-> ##[1:8] !sampler_hold)
        else $error("conversion kept after early release");
    a_shift_on_fall: assert property (
        !select_n && !$past(select_n) && $changed(serial_data) |-> $fell(link_sclk))
        else $error("serial data moved off a falling clock");
    a_reset_idle: assert property (disable iff (1'b0) reset |=> !sampler_hold)
        else $error("conversion running out of reset");
endmodule : slsi_converter_assertions

bind slsi_converter slsi_converter_assertions #(
    .CONVERT_COUNT(CONVERT_COUNT)
) u_slsi_converter_assertions (
    .clock(clock), .reset(reset), .link_sclk(link_sclk), .select_n(select_n),
    .frame_sync_strobe(frame_sync_strobe), .serial_data(serial_data),
    .serial_data_oe_n(serial_data_oe_n), .sample_value(sample_value),
    .sampler_hold(sampler_hold)
);

// [sim/slsi_converter_tb.sv]
// Self-checking bench for the serial sampling converter
`timescale 1ns/100ps
module slsi_converter_tb;
    import slsi_pkg::*;
    localparam int CONVERT_COUNT = 20;
    localparam int CYCLE_LIMIT   = 20000;

    logic                    clock;
    logic                    reset;
    logic                    link_sclk;
    logic                    select_n;
    logic                    frame_sync_strobe;
    logic                    serial_data;
    logic                    serial_data_oe_n;
    logic                    sampler_hold;
    logic                    rx_valid;
    logic [RESULT_WIDTH-1:0] sample_value;
    logic [RESULT_WIDTH-1:0] last_value;
    logic [WORD_WIDTH-1:0]   rx_word;
    logic [WORD_WIDTH-1:0]   exp_q[$];
    int                      fails;
    int                      n_tests;
    int                      cycles;
    int                      seed;

    slsi_converter #(.CONVERT_COUNT(CONVERT_COUNT)) u_slsi_converter (
        .clock(clock), .reset(reset), .link_sclk(link_sclk), .select_n(select_n),
        .frame_sync_strobe(frame_sync_strobe), .serial_data(serial_data),
        .serial_data_oe_n(serial_data_oe_n), .sample_value(sample_value),
        .sampler_hold(sampler_hold)
    );
    slsi_host_model u_slsi_host_model (
        .link_sclk(link_sclk), .select_n(select_n), .frame_sync_strobe(frame_sync_strobe),
        .serial_data(serial_data), .serial_data_oe_n(serial_data_oe_n),
        .rx_word(rx_word), .rx_valid(rx_valid)
    );

    // System clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    // Verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            fails++;
            test_done();
        end
    end

    // Each gathered word against the oldest note
    always @(posedge rx_valid) begin
        n_tests++;
        if (exp_q.size() == 0) begin
            fails++;
            $display("wrong value rx_word expected none seen %h", rx_word);
        end else begin
            if (rx_word !== exp_q[0]) begin
                fails++;
                $display("wrong value rx_word expected %h seen %h", exp_q[0], rx_word);
            end
            void'(exp_q.pop_front());
        end
    end

    // A word carries the previous frame's sample; a dropped frame leaves it
    task automatic run_frame(input logic sel_mode, input int n_pre, input logic full);
        @(posedge clock);
        #1 sample_value = RESULT_WIDTH'($random(seed));
        if (full) begin
            exp_q.push_back({last_value, PAD_BITS});
            last_value = sample_value;
        end
        u_slsi_host_model.frame(sel_mode, n_pre, full ? 16 : 0, full ? 400 : 0);
    endtask : run_frame

    // Main sequence
    initial begin
        seed = 86;
        fails = 0;
        n_tests = 0;
        cycles = 0;
        reset = 1'b1;
        sample_value = '0;
        last_value = '0;
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        repeat (4) @(posedge clock);
        run_frame(1'b1, 0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            run_frame(1'b1, 0, 1'b1);
        end
        for (int k = 0; k < 3; k++) begin
            run_frame(1'b0, k, 1'b1);
        end
        run_frame(1'b1, 0, 1'b0);
        run_frame(1'b1, 0, 1'b1);
        run_frame(1'b0, 1, 1'b1);
        run_frame(1'b0, 0, 1'b0);
        run_frame(1'b1, 0, 1'b1);
        repeat (10) @(posedge clock);
        // Every noted word must have come back
        if (exp_q.size() != 0) begin
            fails++;
            $display("wrong value exp_q size expected 0 seen %0d", exp_q.size());
        end
        test_done();
    end
endmodule : slsi_converter_tb

// [sim/slsi_host_model.sv]
// Host serial port model: makes select, frame sync and serial clock, gathers words
`timescale 1ns/100ps
module slsi_host_model (
    // Host pins toward the converter
    output logic        link_sclk,
    output logic        select_n,
    output logic        frame_sync_strobe,
    input  wire logic   serial_data,
    input  wire logic   serial_data_oe_n,
    // Gathered word toward the bench
    output logic [15:0] rx_word,
    output logic        rx_valid
);
    localparam real HALF_NS = 62.5;

    // Idle pins; the serial clock stands still between frames
    initial begin
        link_sclk = 1'b0;
        select_n = 1'b1;
        frame_sync_strobe = 1'b0;
        rx_word = '0;
        rx_valid = 1'b0;
    end

    // One frame; a zero bit count with no tail releases select early
    task automatic frame(input logic sel_mode, input int n_pre, input int n_bits,
                         input int tail_ns);
        int i;
        frame_sync_strobe = sel_mode; // Level settles before the select fall
        #100;
        select_n = 1'b0; // Held for the conversion in full frames
        #100;
        // Frame mode: idle clocks, then a sync pulse launched on rising edges
        if (!sel_mode && n_bits > 0) begin
            for (i = 0; i < n_pre + 2; i++) begin
                #HALF_NS link_sclk = 1'b1;
                frame_sync_strobe = (i == n_pre);
                #HALF_NS link_sclk = 1'b0;
            end
        end
        // Sample on rising edges; a released pin reads inverted, so it shows up
        for (i = 0; i < n_bits; i++) begin
            #HALF_NS link_sclk = 1'b1;
            rx_word[15-i] = serial_data_oe_n ? ~serial_data : serial_data;
            #HALF_NS link_sclk = 1'b0;
        end
        #(tail_ns); // Select low well past the scaled conversion time
        select_n = 1'b1;
        if (n_bits == 16) begin
            rx_valid = 1'b1;
            #1 rx_valid = 1'b0;
        end
        #300;
    endtask : frame
endmodule : slsi_host_model
